// >>> afe_cfg_pkg.sv
package afe_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_OSC = 4'h3;
  localparam logic [3:0] IDX_PHASE = 4'h4;
  localparam logic [3:0] IDX_CLAMP_START = 4'h5;
  localparam logic [3:0] IDX_CLAMP_LEN = 4'h6;
  localparam logic [3:0] IDX_LS_WIDTH = 4'h7;
  localparam logic [3:0] IDX_RED_RANGE = 4'h8;
  localparam logic [3:0] IDX_GREEN_RANGE = 4'h9;
  localparam logic [3:0] IDX_BLUE_RANGE = 4'ha;
  localparam logic [3:0] IDX_RED_SHIFT = 4'hb;
  localparam logic [3:0] IDX_GREEN_SHIFT = 4'hc;
  localparam logic [3:0] IDX_BLUE_SHIFT = 4'hd;
  localparam logic [3:0] IDX_SYNC_CTRL = 4'he;
  localparam logic [3:0] IDX_FIRST = IDX_OSC;
  localparam logic [3:0] IDX_LAST = IDX_SYNC_CTRL;
  localparam int ADDR_W = 8;

  // Reset values
  localparam logic [7:0] RST_OSC = 8'h48;
  localparam logic [7:0] RST_PHASE = 8'h80;
  localparam logic [7:0] RST_CLAMP_START = 8'h08;
  localparam logic [7:0] RST_CLAMP_LEN = 8'h14;
  localparam logic [7:0] RST_LS_WIDTH = 8'h20;
  localparam logic [7:0] RST_RANGE = 8'h80;
  localparam logic [7:0] RST_SHIFT = 8'h80;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h40;

  // Field positions
  localparam int OSC_BAND_HI = 7;
  localparam int OSC_BAND_LO = 6;
  localparam int PUMP_HI = 5;
  localparam int PUMP_LO = 3;
  localparam int PHASE_HI = 7;
  localparam int PHASE_LO = 3;
  localparam int SHIFT_HI = 7;
  localparam int SHIFT_LO = 1;
  localparam int SC_LPOL_OVR = 7;
  localparam int SC_LPOL_IN = 6;
  localparam int SC_LPOL_OUT = 5;
  localparam int SC_LSRC_OVR = 4;
  localparam int SC_LSRC_SEL = 3;
  localparam int SC_FS_NOINV = 2;
  localparam int SC_FSRC_OVR = 1;
  localparam int SC_FSRC_SEL = 0;

  // Idle run length that decides the incoming line-sync polarity
  localparam logic [7:0] POL_DET_RUN = 8'h40;

  typedef struct packed {
    logic [1:0] osc_band;
    logic [2:0] pump_current;
    logic [4:0] phase_step;
    logic [7:0] red_range;
    logic [7:0] green_range;
    logic [7:0] blue_range;
    logic [6:0] red_dc_shift;
    logic [6:0] green_dc_shift;
    logic [6:0] blue_dc_shift;
  } analog_cfg_s;

  typedef struct packed {
    logic line_sync_pin;
    logic green_sync_pin;
    logic frame_sync_pin;
    logic sep_frame_pin;
  } sync_pins_s;

  typedef struct packed {
    logic line_in_active;
    logic green_in_active;
    logic sep_frame_chosen;
  } detect_s;

endpackage : afe_cfg_pkg

// >>> video_afe_sync_clamp_config.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Two bits choose PLL oscillator band
// - Three bits choose charge pump current
// - Five-bit sample phase, 1/32 pixel steps
// - Clamp starts N pixels after sync trailing edge
// - Clamp lasts N pixels; host never writes zero
// - Output sync leading edge from phased clock
// - Output sync ends after programmed pixel count
// - Bit 7 chooses detected or given polarity
// - Bit 6 gives incoming line-sync polarity
// - Bit 5 sets output line-sync polarity
// - Bit 4 chooses user or detected source
// - Bit 3 picks line input or green slicer
// - Bit 2 set turns off frame-sync output inversion
// - Bit 1 chooses user or detected frame source
module video_afe_sync_clamp_config
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [afe_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire afe_cfg_pkg::sync_pins_s pins,
  input wire afe_cfg_pkg::detect_s detect,
  output afe_cfg_pkg::analog_cfg_s analog_cfg,
  output logic clamp_active,
  output logic line_sync_out,
  output logic frame_sync_out
);
  import afe_cfg_pkg::*;

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[5:2];
  endfunction : reg_index

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:6] == '0) &&
      (reg_index(a) >= IDX_FIRST) && (reg_index(a) <= IDX_LAST);
  endfunction : addr_hit

  logic [7:0] regs [IDX_FIRST:IDX_LAST];
  logic setup;
  logic wr_en;
  logic [3:0] idx;

  assign setup = psel && !penable;
  assign idx = reg_index(paddr);
  assign wr_en = psel && penable && pwrite && addr_hit(paddr);
  // Zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);

  // Register file
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      regs[IDX_OSC] <= RST_OSC;
      regs[IDX_PHASE] <= RST_PHASE;
      regs[IDX_CLAMP_START] <= RST_CLAMP_START;
      regs[IDX_CLAMP_LEN] <= RST_CLAMP_LEN;
      regs[IDX_LS_WIDTH] <= RST_LS_WIDTH;
      regs[IDX_RED_RANGE] <= RST_RANGE;
      regs[IDX_GREEN_RANGE] <= RST_RANGE;
      regs[IDX_BLUE_RANGE] <= RST_RANGE;
      regs[IDX_RED_SHIFT] <= RST_SHIFT;
      regs[IDX_GREEN_SHIFT] <= RST_SHIFT;
      regs[IDX_BLUE_SHIFT] <= RST_SHIFT;
      regs[IDX_SYNC_CTRL] <= RST_SYNC_CTRL;
    end
    else if (wr_en)
    begin
      regs[idx] <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (setup && !pwrite && addr_hit(paddr))
    begin
      prdata <= {24'h00_0000, regs[idx]};
    end
    else if (setup)
    begin
      prdata <= 32'h0000_0000;
    end
  end

  // Analog settings; unused low bits are simply not passed on
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      analog_cfg <= '0;
    end
    else
    begin
      analog_cfg.osc_band <= regs[IDX_OSC][OSC_BAND_HI:OSC_BAND_LO];
      analog_cfg.pump_current <= regs[IDX_OSC][PUMP_HI:PUMP_LO];
      analog_cfg.phase_step <= regs[IDX_PHASE][PHASE_HI:PHASE_LO];
      analog_cfg.red_range <= regs[IDX_RED_RANGE];
      analog_cfg.green_range <= regs[IDX_GREEN_RANGE];
      analog_cfg.blue_range <= regs[IDX_BLUE_RANGE];
      analog_cfg.red_dc_shift <= regs[IDX_RED_SHIFT][SHIFT_HI:SHIFT_LO];
      analog_cfg.green_dc_shift <= regs[IDX_GREEN_SHIFT][SHIFT_HI:SHIFT_LO];
      analog_cfg.blue_dc_shift <= regs[IDX_BLUE_SHIFT][SHIFT_HI:SHIFT_LO];
    end
  end

  // Pin synchronisers: three stages, level moves when stages 2 and 3 agree
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] pin_lvl;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_lvl <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (sync2[i] == sync3[i])
        begin
          pin_lvl[i] <= sync3[i];
        end
      end
    end
  end

  logic line_pin;
  logic green_pin;
  logic frame_pin;
  logic sep_pin;
  assign line_pin = pin_lvl[3];
  assign green_pin = pin_lvl[2];
  assign frame_pin = pin_lvl[1];
  assign sep_pin = pin_lvl[0];

  // Line-sync source choice
  logic [7:0] sc;
  logic use_green;
  logic line_raw;
  assign sc = regs[IDX_SYNC_CTRL];

  always_comb
  begin
    if (sc[SC_LSRC_OVR])
    begin
      use_green = sc[SC_LSRC_SEL];
    end
    else if (detect.line_in_active && detect.green_in_active)
    begin
      use_green = sc[SC_LSRC_SEL];
    end
    else
    begin
      use_green = detect.green_in_active && !detect.line_in_active;
    end
  end

  assign line_raw = use_green ? green_pin : line_pin;

  // Polarity detect: the level that idles long is the inactive one
  logic [7:0] run_len;
  logic raw_prev;
  logic det_active_high;
  logic active_high;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_len <= 8'h00;
      raw_prev <= 1'b0;
      det_active_high <= 1'b1;
    end
    else
    begin
      raw_prev <= line_raw;
      if (line_raw != raw_prev)
      begin
        run_len <= 8'h00;
      end
      else if (run_len != POL_DET_RUN)
      begin
        run_len <= run_len + 8'h01;
      end
      else
      begin
        det_active_high <= !line_raw;
      end
    end
  end

  assign active_high = sc[SC_LPOL_OVR] ? sc[SC_LPOL_IN] : det_active_high;

  logic line_act;
  logic line_act_prev;
  logic lead_edge;
  logic trail_edge;
  assign line_act = line_raw ~^ active_high;
  assign lead_edge = line_act && !line_act_prev;
  assign trail_edge = !line_act && line_act_prev;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      line_act_prev <= 1'b0;
    end
    else
    begin
      line_act_prev <= line_act;
    end
  end

  // Clamp: delay then duration, both in pixel periods
  logic [7:0] clamp_dly;
  logic [7:0] clamp_cnt;
  logic clamp_wait;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clamp_dly <= 8'h00;
      clamp_cnt <= 8'h00;
      clamp_wait <= 1'b0;
      clamp_active <= 1'b0;
    end
    else if (trail_edge)
    begin
      // Zero start is illegal; treated as one so the clamp still runs
      clamp_dly <= (regs[IDX_CLAMP_START] == 8'h00) ? 8'h01 : regs[IDX_CLAMP_START];
      clamp_wait <= 1'b1;
      clamp_active <= 1'b0;
    end
    else if (clamp_wait)
    begin
      if (clamp_dly == 8'h01)
      begin
        clamp_wait <= 1'b0;
        clamp_active <= (regs[IDX_CLAMP_LEN] != 8'h00);
        clamp_cnt <= regs[IDX_CLAMP_LEN];
      end
      clamp_dly <= clamp_dly - 8'h01;
    end
    else if (clamp_active)
    begin
      clamp_cnt <= clamp_cnt - 8'h01;
      if (clamp_cnt == 8'h01)
      begin
        clamp_active <= 1'b0;
      end
    end
  end

  // Output line sync; clk stands for the phase-adjusted PLL clock
  logic [7:0] ls_cnt;
  logic ls_on;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ls_cnt <= 8'h00;
      ls_on <= 1'b0;
    end
    else if (lead_edge && regs[IDX_LS_WIDTH] != 8'h00)
    begin
      ls_on <= 1'b1;
      ls_cnt <= regs[IDX_LS_WIDTH];
    end
    else if (ls_on)
    begin
      ls_cnt <= ls_cnt - 8'h01;
      if (ls_cnt == 8'h01)
      begin
        ls_on <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      line_sync_out <= 1'b0;
    end
    else
    begin
      line_sync_out <= ls_on ^ sc[SC_LPOL_OUT];
    end
  end

  // Frame sync path
  logic use_sep;
  assign use_sep = sc[SC_FSRC_OVR] ? sc[SC_FSRC_SEL] : detect.sep_frame_chosen;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frame_sync_out <= 1'b1;
    end
    else
    begin
      frame_sync_out <= (use_sep ? sep_pin : frame_pin) ^ !sc[SC_FS_NOINV];
    end
  end

endmodule : video_afe_sync_clamp_config
`default_nettype wire

// >>> afe_cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module afe_cfg_checker
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [afe_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire afe_cfg_pkg::analog_cfg_s analog_cfg,
  input wire logic clamp_active,
  input wire logic line_sync_out
);
  import afe_cfg_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic acc;
  logic wr;
  logic bad;
  logic [7:0] len;
  logic [7:0] run;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign bad = paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0 || paddr[5:2] < IDX_FIRST
    || paddr[5:2] > IDX_LAST;
  // Shadow of clamp length so the width check needs no bus snooping by the bench
  always_ff @(posedge clk)
  begin
    if (rst)
      len <= RST_CLAMP_LEN;
    else if (wr && paddr == 8'h18)
      len <= pwdata[7:0];
  end
  always_ff @(posedge clk)
  begin
    run <= (clamp_active && !rst) ? run + 8'h1 : 8'h0;
  end
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_err; acc |-> pslverr == bad; endproperty
  a_err: assert property (p_err) else $error("slave error flag wrong");
  property p_rdbad; acc && !pwrite && bad |-> prdata == 32'h0; endproperty
  a_rdbad: assert property (p_rdbad) else $error("unmapped read not zero");
  property p_band; wr && paddr == 8'h0c |-> ##2 analog_cfg.osc_band == $past(pwdata[7:6], 2);
  endproperty
  a_band: assert property (p_band) else $error("band field wrong");
  property p_pump; wr && paddr == 8'h0c |-> ##2 analog_cfg.pump_current == $past(pwdata[5:3], 2);
  endproperty
  a_pump: assert property (p_pump) else $error("pump field wrong");
  property p_phase; wr && paddr == 8'h10 |-> ##2 analog_cfg.phase_step == $past(pwdata[7:3], 2);
  endproperty
  a_phase: assert property (p_phase) else $error("phase field wrong");
  property p_clamp; $fell(clamp_active) |-> run == len; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp length wrong");
  property p_rst; disable iff (1'b0) rst |=> prdata == 32'h0 && !clamp_active && !line_sync_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  c_clamp: cover property ($fell(clamp_active));
  c_err: cover property (acc && pslverr);
  c_line: cover property ($rose(line_sync_out));
endmodule : afe_cfg_checker
bind video_afe_sync_clamp_config afe_cfg_checker afe_cfg_checker_i (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .analog_cfg, .clamp_active,
  .line_sync_out);
`default_nettype wire

// >>> tb_video_afe_sync_clamp_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_video_afe_sync_clamp_config;
  import afe_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sync_pins_s pins = '0;
  detect_s detect = '0;
  analog_cfg_s analog_cfg;
  logic clamp_active;
  logic line_sync_out;
  logic frame_sync_out;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int checks = 0;
  video_afe_sync_clamp_config video_afe_sync_clamp_config_i (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .detect, .analog_cfg,
    .clamp_active, .line_sync_out, .frame_sync_out);
  initial forever #50 clk = ~clk;
  task automatic summarize;
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      err_count++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Pin held 3 cycles so the output pulse starts only after it drops
  // Pin is toggled from its idle level, so idle-high lines work too
  task automatic pulse(input logic g, input logic pol, input logic k, output int d, output int w);
    d = 0;
    w = 0;
    @(posedge clk);
    pins <= pins ^ {~g, g, 2'b00};
    repeat (3) @(posedge clk);
    pins <= pins ^ {~g, g, 2'b00};
    while ((k ? line_sync_out : clamp_active) !== pol && d < 300)
    begin
      @(negedge clk);
      d++;
    end
    while ((k ? line_sync_out : clamp_active) === pol && w < 300)
    begin
      @(negedge clk);
      w++;
    end
    if (d == 300 || w == 300)
    begin
      err_count++;
      summarize();
    end
    // Long tail lets the clamp end before the next line arrives
    repeat (30) @(posedge clk);
  endtask : pulse
  task automatic t_regs;
    logic [7:0] dv [12] = '{8'h48, 8'h80, 8'h08, 8'h14, 8'h20, 8'h80, 8'h80, 8'h80, 8'h80,
      8'h80, 8'h80, 8'h40};
    for (int i = 0; i < 12; i++)
    begin
      apb(1'b0, 8'(4 * (i + 3)), 32'h0);
      chk("reset value", {24'h0, dv[i]}, rd);
      apb(1'b1, 8'(4 * (i + 3)), 32'hffff_ff00 + 32'(17 * (i + 1)));
      apb(1'b0, 8'(4 * (i + 3)), 32'h0);
      chk("readback", 32'(17 * (i + 1)), rd);
    end
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : t_regs
  task automatic t_osc;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 8'h0c, 32'({i[1:0], i[2:0], 3'h0}));
      apb(1'b1, 8'h10, 32'({i[2:0], 2'h2, 3'h0}));
      repeat (2) @(negedge clk);
      chk("band", 32'(i[1:0]), 32'(analog_cfg.osc_band));
      chk("pump", 32'(i[2:0]), 32'(analog_cfg.pump_current));
      chk("phase", 32'({i[2:0], 2'h2}), 32'(analog_cfg.phase_step));
    end
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 8'(8'h20 + 4 * i), 32'(8'h13 * (i + 1)));
    end
    repeat (2) @(negedge clk);
    chk("red range", 32'h13, 32'(analog_cfg.red_range));
    chk("green range", 32'h26, 32'(analog_cfg.green_range));
    chk("blue range", 32'h39, 32'(analog_cfg.blue_range));
    chk("red shift", 32'h26, 32'(analog_cfg.red_dc_shift));
    chk("green shift", 32'h2f, 32'(analog_cfg.green_dc_shift));
    chk("blue shift", 32'h39, 32'(analog_cfg.blue_dc_shift));
  endtask : t_osc
  task automatic t_bad;
    logic [7:0] ba [4] = '{8'h08, 8'h3c, 8'h0e, 8'h4c};
    apb(1'b1, 8'h0c, 32'h5a);
    foreach (ba[i])
    begin
      apb(1'b1, ba[i], 32'hff);
      chk("write error", 32'h1, er);
      apb(1'b0, ba[i], 32'h0);
      chk("read error", 32'h1, er);
      chk("read zero", 32'h0, rd);
    end
    apb(1'b0, 8'h0c, 32'h0);
    chk("kept value", 32'h5a, rd);
  endtask : t_bad
  task automatic t_sync;
    int d;
    int d1;
    int w;
    apb(1'b1, 8'h1c, 32'h5);
    apb(1'b1, 8'h38, 32'hd0);
    pulse(1'b0, 1'b1, 1'b1, d, w);
    chk("line out width", 32'h5, w);
    apb(1'b1, 8'h38, 32'hf0);
    pulse(1'b0, 1'b0, 1'b1, d, w);
    chk("line out low width", 32'h5, w);
    apb(1'b1, 8'h38, 32'hd8);
    pulse(1'b1, 1'b1, 1'b1, d, w);
    chk("green source width", 32'h5, w);
    detect <= 3'b010;
    apb(1'b1, 8'h38, 32'hc0);
    pulse(1'b1, 1'b1, 1'b1, d, w);
    chk("detected source width", 32'h5, w);
    apb(1'b1, 8'h38, 32'hd0);
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b1, 8'h14, 32'h2);
    pulse(1'b0, 1'b1, 1'b0, d1, w);
    chk("clamp width", 32'h3, w);
    // Compared as a difference so the input sync latency cancels
    apb(1'b1, 8'h14, 32'h6);
    apb(1'b1, 8'h18, 32'hff);
    pulse(1'b0, 1'b1, 1'b0, d, w);
    chk("clamp delay step", 32'h4, d - d1);
    chk("clamp max width", 32'hff, w);
  endtask : t_sync
  // Line pin idles high here, so auto detect has to learn active low
  task automatic t_pol;
    int d;
    int d1;
    int w;
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b1, 8'h38, 32'h10);
    pins <= 4'b1000;
    repeat (100) @(posedge clk);
    pulse(1'b0, 1'b1, 1'b1, d1, w);
    chk("auto polarity width", 32'h5, w);
    apb(1'b1, 8'h38, 32'h90);
    pulse(1'b0, 1'b1, 1'b1, d, w);
    chk("given low polarity delay", 32'(d1), d);
    apb(1'b1, 8'h38, 32'hd0);
    repeat (20) @(posedge clk);
    pulse(1'b0, 1'b1, 1'b1, d, w);
    chk("given high polarity delay", 32'h3, d - d1);
    chk("given high polarity width", 32'h5, w);
  endtask : t_pol
  task automatic t_frame;
    logic [8:0] ft [6] = '{9'h00d, 9'h004, 9'h00e, 9'h007, 9'h008, 9'h001};
    pins <= 4'b0010;
    detect <= 3'b001;
    foreach (ft[i])
    begin
      apb(1'b1, 8'h38, 32'(ft[i][8:1]));
      repeat (8) @(negedge clk);
      chk("frame out", 32'(ft[i][0]), 32'(frame_sync_out));
    end
  endtask : t_frame
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_osc();
    t_bad();
    t_sync();
    t_pol();
    t_frame();
    summarize();
  end
endmodule : tb_video_afe_sync_clamp_config
`default_nettype wire
